// ### hw/pwmtb_duty_ch.sv
// One duty compare channel: turns counter position into the generator level.
`timescale 1ns/1ps
module pwmtb_duty_ch
    import pwmtb_pkg::*;
(
    input  wire logic             pclk,    // CPU clock
    input  wire logic             presetn, // Asynchronous reset, active low
    input  wire logic             active,  // Time base running
    input  wire logic             centre,  // Centre-aligned mode
    input  wire logic             down,    // Counter counting down
    input  wire logic [CNT_W-1:0] cnt,     // Counter value
    input  wire logic [CNT_W-1:0] period,  // Active reload value
    input  wire logic [CNT_W-1:0] duty,    // Active compare value
    output logic                  gen_out  // Generator level, positive logic
);
    logic next_gen_out;

    always_comb begin
        if (duty == DUTY_ZERO) begin
            next_gen_out = 1'b0; // [RL6]
        end else if (duty == DUTY_FULL || duty > period) begin
            next_gen_out = 1'b1; // [RL5] [RL6]
        end else if (!centre) begin
            next_gen_out = (cnt < duty); // [RL11] [RL13]
        end else if (down) begin
            next_gen_out = (cnt < duty); // [RL19] [RL15]
        end else begin
            next_gen_out = (cnt < duty) && (cnt != DUTY_ZERO); // [RL15]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_out <= 1'b0; // [RL17]
        end else if (!active) begin
            gen_out <= 1'b0;
        end else begin
            gen_out <= next_gen_out;
        end
    end
endmodule

// ### hw/pwmtb_pkg.sv
// Package with register map, field positions and constants of the PWM time base.
// Operation
// (RL1) Counter advances on CPU clock divided by a programmable prescaler; 12-bit count and compares.
// (RL2) Run bit 7 of control one starts the time base; clear keeps it idle.
// (RL3) Period buffer loads into reload on run rising edge, or on event with load.
// (RL4) Duty buffers load to compares only with load, run and a match or underflow.
// (RL5) Compare above the active reload keeps that channel output high.
// (RL6) Compare 000H holds output low; FFFH holds it high.
// (RL7) Programming mode tri-states pins and stops; on exit pins show port latch.
// (RL8) Period writes go to a holding register, never straight to the reload.
// (RL9) Each 12-bit value joins high byte low nibble above the low byte.
// (RL10) Period and duty are double buffered: software buffer and active buffer.
// (RL11) Edge mode counts up from 0; duty match drives generator output low.
// (RL12) Edge mode period match drives output high, loads if set, requests interrupt.
// (RL13) Edge period is period plus one ticks; high time is duty ticks.
// (RL14) Centre mode period lasts twice the period value in ticks.
// (RL15) Centre mode high time is twice duty minus one ticks.
// (RL16) Interrupt once per period: edge on match, centre on underflow.
// (RL17) After reset each channel level follows its polarity setting.
// (RL18) PWM pins are high impedance right after reset.
// (RL19) Centre mode counts up, turns down at period, loads on underflow.
// (RL20) Centre interrupt at underflow when type bit 0, at up period match when 1.
// (RL21) Edge mode counter restarts from zero the tick after period match.
// (RL22) With load clear at an event, active period and duty stay unchanged.
package pwmtb_pkg;
    localparam int CNT_W     = 12;
    localparam int NUM_CH    = 4;
    localparam int PRE_W     = 7;
    localparam int PSEL_W    = 3;
    localparam int ADDR_W    = 8;
    localparam int REG_IDX_W = 4;

    // Byte addresses of the registers.
    localparam logic [ADDR_W-1:0] OFF_CTRL_ONE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL_THREE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_POLARITY   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PERIOD_LO  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PERIOD_HI  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DUTY_BASE  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_DUTY_STEP  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DUTY_HI    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h34;

    // Decoded register indices.
    localparam logic [REG_IDX_W-1:0] IDX_CTRL_ONE   = 4'h0;
    localparam logic [REG_IDX_W-1:0] IDX_CTRL_THREE = 4'h1;
    localparam logic [REG_IDX_W-1:0] IDX_POLARITY   = 4'h2;
    localparam logic [REG_IDX_W-1:0] IDX_PERIOD_LO  = 4'h3;
    localparam logic [REG_IDX_W-1:0] IDX_PERIOD_HI  = 4'h4;
    localparam logic [REG_IDX_W-1:0] IDX_DUTY_LO0   = 4'h5;
    localparam logic [REG_IDX_W-1:0] IDX_STATUS     = 4'hD;
    localparam logic [REG_IDX_W-1:0] IDX_NONE       = 4'hF;

    // Control one fields.
    localparam int BIT_RUN    = 7;
    localparam int BIT_LOAD   = 6;
    localparam int BIT_CENTRE = 5;
    localparam int PSEL_LSB   = 0;
    // Control three fields.
    localparam int BIT_INT_TYPE = 0;
    localparam int BIT_IRQ_EN   = 1;
    // Status fields.
    localparam int BIT_ST_DOWN  = 12;
    localparam int BIT_ST_RUN   = 13;

    localparam int LOW_W  = 8;
    localparam int HIGH_W = 4;

    localparam logic [CNT_W-1:0]  DUTY_ZERO     = 12'h000;
    localparam logic [CNT_W-1:0]  DUTY_FULL     = 12'hFFF;
    localparam logic [CNT_W-1:0]  CNT_ONE       = 12'h001;
    localparam logic [CNT_W-1:0]  PERIOD_RESET  = 12'h000;
    localparam logic [PRE_W-1:0]  PRE_ONE       = 7'h01;
    localparam logic [7:0]        CTRL_RESET    = 8'h00;
    localparam logic [NUM_CH-1:0] POL_RESET     = 4'h0;
endpackage

// ### hw/pwmtb_prescaler.sv
// Prescaler that divides the CPU clock into PWM counter ticks.
`timescale 1ns/1ps
module pwmtb_prescaler
    import pwmtb_pkg::*;
(
    input  wire logic              pclk,     // CPU clock
    input  wire logic              presetn,  // Asynchronous reset, active low
    input  wire logic              active,   // Time base running
    input  wire logic [PSEL_W-1:0] psel_div, // Divide by two to this power
    output logic                   tick      // One-cycle counter advance
);
    logic [PRE_W-1:0] pcnt;
    logic [PRE_W-1:0] limit;

    assign limit = PRE_W'((PRE_ONE << psel_div) - PRE_ONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt <= '0;
            tick <= 1'b0;
        end else if (!active) begin
            pcnt <= '0;
            tick <= 1'b0;
        end else if (pcnt >= limit) begin // [RL1]
            pcnt <= '0;
            tick <= 1'b1;
        end else begin
            pcnt <= PRE_W'(pcnt + PRE_ONE);
            tick <= 1'b0;
        end
    end
endmodule

// ### hw/pwmtb_top.sv
// PWM time base with four duty channels and an APB register slave.
`timescale 1ns/1ps
module pwmtb_top
    import pwmtb_pkg::*;
(
    input  wire logic              pclk,      // CPU clock, 40 MHz
    input  wire logic              presetn,   // Asynchronous reset, active low
    input  wire logic              psel,      // APB select
    input  wire logic              penable,   // APB enable
    input  wire logic              pwrite,    // APB write
    input  wire logic [ADDR_W-1:0] paddr,     // APB byte address
    input  wire logic [31:0]       pwdata,    // APB write data
    output logic      [31:0]       prdata,    // APB read data
    output logic                   pready,    // APB ready
    output logic                   pslverr,   // APB error, unmapped address
    input  wire logic              icp_mode,  // Programming mode pin
    input  wire logic [NUM_CH-1:0] port_latch, // Port register values
    output logic      [NUM_CH-1:0] pwm_out,   // PWM pin levels
    output logic      [NUM_CH-1:0] pwm_oe,    // PWM pin drive enables
    output logic                   pwm_irq    // Period interrupt request pulse
);
    // ***************************************************************
    // Register decode
    // ***************************************************************
    function automatic logic [REG_IDX_W-1:0] decode_reg(input logic [ADDR_W-1:0] a);
        logic [REG_IDX_W-1:0] idx;
        idx = IDX_NONE;
        if (a == OFF_CTRL_ONE) begin
            idx = IDX_CTRL_ONE;
        end else if (a == OFF_CTRL_THREE) begin
            idx = IDX_CTRL_THREE;
        end else if (a == OFF_POLARITY) begin
            idx = IDX_POLARITY;
        end else if (a == OFF_PERIOD_LO) begin
            idx = IDX_PERIOD_LO;
        end else if (a == OFF_PERIOD_HI) begin
            idx = IDX_PERIOD_HI;
        end else if (a == OFF_STATUS) begin
            idx = IDX_STATUS;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (a == ADDR_W'(OFF_DUTY_BASE + OFF_DUTY_STEP * c)) begin
                    idx = REG_IDX_W'(IDX_DUTY_LO0 + 2 * c);
                end
                if (a == ADDR_W'(OFF_DUTY_BASE + OFF_DUTY_STEP * c + OFF_DUTY_HI)) begin
                    idx = REG_IDX_W'(IDX_DUTY_LO0 + 2 * c + 1);
                end
            end
        end
        return idx;
    endfunction

    // ***************************************************************
    // State
    // ***************************************************************
    typedef enum logic [1:0] {
        PWMTB_IDLE = 2'b01,
        PWMTB_RUN  = 2'b10
    } pwmtb_state_e;

    pwmtb_state_e         state;
    logic [7:0]           ctrl_one;
    logic [7:0]           ctrl_three;
    logic [NUM_CH-1:0]    polarity;
    logic [CNT_W-1:0]     period_buf;
    logic [CNT_W-1:0]     period_act;
    logic [CNT_W-1:0]     duty_buf [NUM_CH];
    logic [CNT_W-1:0]     duty_act [NUM_CH];
    logic [CNT_W-1:0]     cnt;
    logic                 down;
    logic                 icp_meta;
    logic                 icp_sync;
    logic                 icp_prev;
    logic                 port_mode;
    logic                 drive_en;
    logic                 run_prev;
    logic                 tick;
    logic [NUM_CH-1:0]    gen_out;

    logic                 run_bit;
    logic                 load_bit;
    logic                 centre;
    logic                 active;
    logic                 run_rise;
    logic                 up_match;
    logic                 underflow;
    logic                 period_event;
    logic                 irq_event;
    logic                 wr_en;
    logic [REG_IDX_W-1:0] wr_idx;
    logic [REG_IDX_W-1:0] rd_idx;
    logic [31:0]          next_prdata;

    assign run_bit  = ctrl_one[BIT_RUN];
    assign load_bit = ctrl_one[BIT_LOAD];
    assign centre   = ctrl_one[BIT_CENTRE];
    assign active   = (state == PWMTB_RUN); // [RL2]
    assign run_rise = run_bit && !run_prev && !icp_sync;
    assign wr_en    = psel && penable && pready && pwrite;
    assign wr_idx   = decode_reg(paddr);
    assign rd_idx   = decode_reg(paddr);

    // ***************************************************************
    // Programming mode synchroniser
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icp_meta <= 1'b0;
            icp_sync <= 1'b0;
            icp_prev <= 1'b0;
        end else begin
            icp_meta <= icp_mode;
            icp_sync <= icp_meta;
            icp_prev <= icp_sync;
        end
    end

    // ***************************************************************
    // Run state machine
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= PWMTB_IDLE;
            run_prev <= 1'b0;
        end else begin
            run_prev <= run_bit && !icp_sync;
            case (state)
                PWMTB_IDLE: begin
                    if (run_rise) begin
                        state <= PWMTB_RUN; // [RL2]
                    end
                end
                PWMTB_RUN: begin
                    if (!run_bit || icp_sync) begin
                        state <= PWMTB_IDLE; // [RL2] [RL7]
                    end
                end
                default: begin
                    state <= PWMTB_IDLE;
                end
            endcase
        end
    end

    // ***************************************************************
    // Counter
    // ***************************************************************
    pwmtb_prescaler u_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .active   (active),
        .psel_div (ctrl_one[PSEL_LSB +: PSEL_W]),
        .tick     (tick)
    );

    assign up_match     = tick && !down && (cnt == period_act);
    assign underflow    = tick && down && (cnt == DUTY_ZERO);
    assign period_event = centre ? underflow : up_match; // [RL16]
    assign irq_event    = centre ? (ctrl_three[BIT_INT_TYPE] ? up_match : underflow)
                                 : up_match; // [RL20] [RL16]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            down <= 1'b0;
        end else if (!active) begin
            cnt  <= '0;
            down <= 1'b0;
        end else if (tick) begin
            if (!centre) begin
                down <= 1'b0;
                if (cnt == period_act) begin
                    cnt <= '0; // [RL21] [RL13]
                end else begin
                    cnt <= CNT_W'(cnt + CNT_ONE); // [RL11]
                end
            end else if (!down) begin
                if (cnt == period_act) begin
                    down <= 1'b1; // [RL19] [RL14]
                    cnt  <= CNT_W'(cnt - CNT_ONE);
                end else begin
                    cnt <= CNT_W'(cnt + CNT_ONE);
                end
            end else if (cnt == DUTY_ZERO) begin
                down <= 1'b0; // [RL19]
                cnt  <= CNT_ONE;
            end else begin
                cnt <= CNT_W'(cnt - CNT_ONE);
            end
        end
    end

    // ***************************************************************
    // Active period and compare buffers
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_act <= PERIOD_RESET;
        end else if (run_rise) begin
            period_act <= period_buf; // [RL3]
        end else if (active && load_bit && period_event) begin
            period_act <= period_buf; // [RL3] [RL10] [RL12] [RL19]
        end
    end

    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    duty_act[c] <= DUTY_ZERO;
                end else if (active && load_bit && period_event) begin
                    duty_act[c] <= duty_buf[c]; // [RL4] [RL10] [RL22]
                end
            end

            pwmtb_duty_ch u_ch (
                .pclk    (pclk),
                .presetn (presetn),
                .active  (active),
                .centre  (centre),
                .down    (down),
                .cnt     (cnt),
                .period  (period_act),
                .duty    (duty_act[c]),
                .gen_out (gen_out[c])
            );
        end
    endgenerate

    // ***************************************************************
    // Interrupt request
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_irq <= 1'b0;
        end else begin
            pwm_irq <= active && irq_event && ctrl_three[BIT_IRQ_EN]; // [RL12] [RL16]
        end
    end

    // ***************************************************************
    // Pin drive
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_en  <= 1'b0; // [RL18]
            port_mode <= 1'b0;
        end else if (icp_sync) begin
            drive_en  <= 1'b0; // [RL7]
            port_mode <= 1'b0;
        end else if (icp_prev) begin
            drive_en  <= 1'b1; // [RL7]
            port_mode <= 1'b1;
        end else if (run_rise) begin
            drive_en  <= 1'b1;
            port_mode <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= '0;
            pwm_oe  <= '0; // [RL18]
        end else begin
            pwm_oe  <= (drive_en && !icp_sync) ? '1 : '0; // [RL7]
            if (port_mode) begin
                pwm_out <= port_latch; // [RL7]
            end else begin
                pwm_out <= gen_out ^ polarity; // [RL17]
            end
        end
    end

    // ***************************************************************
    // Register writes
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one   <= CTRL_RESET;
            ctrl_three <= CTRL_RESET;
            polarity   <= POL_RESET;
            period_buf <= PERIOD_RESET;
        end else if (wr_en) begin
            case (wr_idx)
                IDX_CTRL_ONE:   ctrl_one   <= pwdata[7:0];
                IDX_CTRL_THREE: ctrl_three <= pwdata[7:0];
                IDX_POLARITY:   polarity   <= pwdata[NUM_CH-1:0];
                IDX_PERIOD_LO:  period_buf[LOW_W-1:0] <= pwdata[LOW_W-1:0]; // [RL8] [RL9]
                IDX_PERIOD_HI:  period_buf[CNT_W-1:LOW_W] <= pwdata[HIGH_W-1:0]; // [RL8] [RL9]
                default: begin
                end
            endcase
        end
    end

    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_dbuf
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    duty_buf[c] <= DUTY_ZERO;
                end else if (wr_en && wr_idx == REG_IDX_W'(IDX_DUTY_LO0 + 2 * c)) begin
                    duty_buf[c][LOW_W-1:0] <= pwdata[LOW_W-1:0]; // [RL9] [RL10]
                end else if (wr_en && wr_idx == REG_IDX_W'(IDX_DUTY_LO0 + 2 * c + 1)) begin
                    duty_buf[c][CNT_W-1:LOW_W] <= pwdata[HIGH_W-1:0]; // [RL9] [RL10]
                end
            end
        end
    endgenerate

    // ***************************************************************
    // Register reads and APB answer
    // ***************************************************************
    always_comb begin
        next_prdata = '0;
        case (rd_idx)
            IDX_CTRL_ONE:   next_prdata[7:0] = ctrl_one;
            IDX_CTRL_THREE: next_prdata[7:0] = ctrl_three;
            IDX_POLARITY:   next_prdata[NUM_CH-1:0] = polarity;
            IDX_PERIOD_LO:  next_prdata[LOW_W-1:0] = period_buf[LOW_W-1:0];
            IDX_PERIOD_HI:  next_prdata[HIGH_W-1:0] = period_buf[CNT_W-1:LOW_W];
            IDX_STATUS: begin
                next_prdata[CNT_W-1:0]  = cnt;
                next_prdata[BIT_ST_DOWN] = down;
                next_prdata[BIT_ST_RUN]  = active;
            end
            default: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (rd_idx == REG_IDX_W'(IDX_DUTY_LO0 + 2 * c)) begin
                        next_prdata[LOW_W-1:0] = duty_buf[c][LOW_W-1:0];
                    end
                    if (rd_idx == REG_IDX_W'(IDX_DUTY_LO0 + 2 * c + 1)) begin
                        next_prdata[HIGH_W-1:0] = duty_buf[c][CNT_W-1:LOW_W];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (rd_idx == IDX_NONE);
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule

// ### verif/pwmtb_monitor.sv
// Checker of the PWM time base top-level ports.
`timescale 1ns/1ps
module pwmtb_monitor
    import pwmtb_pkg::*;
(
    input wire logic              pclk,       // clock
    input wire logic              presetn,    // reset
    input wire logic              psel,       // select
    input wire logic              penable,    // enable
    input wire logic              pwrite,     // write
    input wire logic [ADDR_W-1:0] paddr,      // address
    input wire logic [31:0]       pwdata,     // write data
    input wire logic [31:0]       prdata,     // read data
    input wire logic              pready,     // ready
    input wire logic              pslverr,    // error
    input wire logic              icp_mode,   // programming
    input wire logic [NUM_CH-1:0] port_latch, // port levels
    input wire logic [NUM_CH-1:0] pwm_out,    // pin levels
    input wire logic [NUM_CH-1:0] pwm_oe,     // drive enables
    input wire logic              pwm_irq     // interrupt
);
    logic run_q;
    logic wr_ctl;
    assign wr_ctl = psel && penable && pready && pwrite && paddr == OFF_CTRL_ONE;
    // Tracks the run bit so that only a rising edge counts as a start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run_q <= 1'b0;
        else if (wr_ctl)
            run_q <= pwdata[BIT_RUN];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_a: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    slverr_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("bad error response");
    reset_hiz_a: assert property ($rose(presetn) |-> pwm_oe == 4'h0)
        else $error("pins driven after reset");
    oe_equal_a: assert property (pwm_oe == 4'h0 || pwm_oe == 4'hF)
        else $error("enables differ");
    icp_hiz_a: assert property (icp_mode [*5] |-> pwm_oe == 4'h0)
        else $error("pins driven in programming mode");
    icp_exit_a: assert property ($fell(icp_mode) |-> ##6 pwm_oe == 4'hF && pwm_out == port_latch)
        else $error("port levels not shown");
    run_stop_a: assert property (wr_ctl && !pwdata[BIT_RUN] |=> ##2 !pwm_irq [*8])
        else $error("interrupt while idle");
    run_start_a: assert property (wr_ctl && pwdata[BIT_RUN] && !run_q && !icp_mode |-> ##[1:3] pwm_oe == 4'hF)
        else $error("no start on run");
endmodule

bind pwmtb_top pwmtb_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .icp_mode(icp_mode), .port_latch(port_latch),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .pwm_irq(pwm_irq));

// ### verif/pwmtb_stage.sv
// Power switching stage model that resolves the PWM pins.
`timescale 1ns/1ps
module pwmtb_stage
    import pwmtb_pkg::*;
(
    input  wire logic              pclk,  // clock
    input  wire logic [NUM_CH-1:0] level, // driven levels
    input  wire logic [NUM_CH-1:0] drive, // drive enables
    output logic      [NUM_CH-1:0] pin    // pin levels
);
    logic [NUM_CH-1:0] last;
    // An undriven pin floats, so it shows the inverse of the level last driven onto it.
    always_ff @(posedge pclk) last <= (drive & level) | (~drive & last);
    assign pin = (drive & level) | (~drive & ~last);
endmodule

// ### verif/test_pwmtb_top.sv
// Self-checking bench for the PWM time base.
`timescale 1ns/1ps
module test_pwmtb_top;
    import pwmtb_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, icp_mode, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, pwm_irq;
    logic [NUM_CH-1:0] port_latch, pwm_out, pwm_oe, pin;
    logic [CNT_W-1:0]  dv[NUM_CH] = '{12'h004, 12'h000, 12'hFFF, 12'h00C};
    int                mismatches = 0;
    int                checks = 0;
    `define CHK(t, x, y) begin checks++; if ((y) !== (x)) begin mismatches++; \
        $display("Error %s expected %0h seen %0h", t, x, y); end end
    pwmtb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .icp_mode(icp_mode), .port_latch(port_latch),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .pwm_irq(pwm_irq));
    pwmtb_stage i_stage (.pclk(pclk), .level(pwm_out), .drive(pwm_oe), .pin(pin));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20)
            mismatches++;
    endtask
    // Skips one whole period, then counts high pin cycles over the next one.
    task automatic meas(input string name, input int n, input int e[NUM_CH]);
        int k;
        int q;
        int hi[NUM_CH];
        k = 0;
        q = 0;
        hi = '{default: 0};
        repeat (2) begin
            @(posedge pclk);
            while (pwm_irq !== 1'b1 && k < 400) begin
                @(posedge pclk);
                k++;
            end
        end
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            q += int'(pwm_irq === 1'b1);
            for (int c = 0; c < NUM_CH; c++)
                hi[c] += int'(pin[c] === 1'b1);
        end
        `CHK("irq_count", 1, q)
        `CHK("irq_at_end", 1'b1, pwm_irq)
        for (int c = 0; c < NUM_CH; c++)
            `CHK("high_time", e[c], hi[c])
        $display("test %s done", name);
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #500000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, icp_mode, paddr, pwdata} = '0;
        port_latch = 4'hA;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("oe_reset", 4'h0, pwm_oe)
        apb(0, OFF_CTRL_ONE, 0);
        `CHK("ctrl_reset", 32'h0, rd)
        apb(1, OFF_PERIOD_HI, 32'hA5);
        apb(0, OFF_PERIOD_HI, 0);
        `CHK("period_high", 32'h5, rd)
        apb(0, 8'hF0, 0);
        `CHK("unmapped", 2'b10, {err, rd[0]})
        apb(1, OFF_PERIOD_HI, 0);
        apb(1, OFF_PERIOD_LO, 9);
        for (int c = 0; c < NUM_CH; c++) begin
            apb(1, ADDR_W'(OFF_DUTY_BASE + 8 * c), 32'(dv[c][7:0]));
            apb(1, ADDR_W'(OFF_DUTY_BASE + OFF_DUTY_HI + 8 * c), 32'(dv[c][11:8]));
        end
        apb(1, OFF_CTRL_THREE, 2);
        apb(1, OFF_CTRL_ONE, 32'hC0);
        meas("edge", 10, '{4, 0, 10, 10});
        apb(1, OFF_CTRL_ONE, 32'h80);
        apb(1, OFF_PERIOD_LO, 7);
        apb(1, OFF_DUTY_BASE, 2);
        meas("hold", 10, '{4, 0, 10, 10});
        apb(1, OFF_CTRL_ONE, 32'hC0);
        meas("load", 8, '{2, 0, 8, 8});
        apb(0, OFF_STATUS, 0);
        `CHK("status_busy", 1'b1, rd[BIT_ST_RUN])
        apb(1, OFF_CTRL_ONE, 0);
        apb(0, OFF_STATUS, 0);
        `CHK("status_idle", 1'b0, rd[BIT_ST_RUN])
        apb(1, OFF_CTRL_ONE, 32'hE0);
        meas("centre", 14, '{3, 0, 14, 14});
        apb(1, OFF_CTRL_THREE, 3);
        meas("type_one", 14, '{3, 0, 14, 14});
        apb(1, OFF_POLARITY, 1);
        meas("polarity", 14, '{11, 0, 14, 14});
        apb(1, OFF_CTRL_ONE, 32'hE1);
        meas("prescale", 28, '{22, 0, 28, 28});
        icp_mode <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK("icp_oe", 4'h0, pwm_oe)
        icp_mode <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK("icp_exit", 8'hFA, {pwm_oe, pwm_out})
        $display("test programming done");
        report_and_stop();
    end
endmodule
